/* logic/gpb_irq_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-pin edge/level detector with a sticky edge latch
module gpb_irq_detect #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] level_in,
    input wire gpb_pkg::gpb_irq_cfg_t cfg,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] raw_status
);
    // Previous synchronised level
    logic [WIDTH-1:0] prev_reg;
    // Latched edge events
    logic [WIDTH-1:0] edge_reg;
    logic [WIDTH-1:0] edge_next;
    // Edge decoding
    wire [WIDTH-1:0] rise = level_in & ~prev_reg;
    wire [WIDTH-1:0] fall = ~level_in & prev_reg;
    // Polarity picks one edge unless both edges are enabled
    wire [WIDTH-1:0] one_edge = (cfg.irq_event_polarity & rise) | (~cfg.irq_event_polarity & fall);
    wire [WIDTH-1:0] edge_hit = (cfg.irq_both_edges & (rise | fall)) | (~cfg.irq_both_edges & one_edge);
    // Level match follows polarity; levels are never latched
    wire [WIDTH-1:0] level_hit = ~(level_in ^ cfg.irq_event_polarity);
    // Edge-selected pins use the latch
    wire [WIDTH-1:0] edge_mode = ~cfg.irq_sense_select;

    // New edge wins over a clear in the same cycle; latch empties in level mode
    assign edge_next = ((edge_reg & ~clear) | edge_hit) & edge_mode;

    // Edge history and latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= '0;
            edge_reg <= '0;
        end else begin
            prev_reg <= level_in;
            edge_reg <= edge_next;
        end
    end

    // Raw status chooses latch or live level per pin
    assign raw_status = (edge_reg & edge_mode) | (level_hit & cfg.irq_sense_select);
endmodule
`default_nettype wire

/* logic/gpb_pkg.sv */
package gpb_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_DATA_LAST = 12'h3fc;
    localparam logic [11:0] OFS_DIR = 12'h400;
    localparam logic [11:0] OFS_IS = 12'h404;
    localparam logic [11:0] OFS_IBE = 12'h408;
    localparam logic [11:0] OFS_IEV = 12'h40c;
    localparam logic [11:0] OFS_IM = 12'h410;
    localparam logic [11:0] OFS_RIS = 12'h414;
    localparam logic [11:0] OFS_MIS = 12'h418;
    localparam logic [11:0] OFS_ICR = 12'h41c;
    localparam logic [11:0] OFS_AFSEL = 12'h420;
    localparam logic [11:0] OFS_DR2R = 12'h500;
    localparam logic [11:0] OFS_DR4R = 12'h504;
    localparam logic [11:0] OFS_DR8R = 12'h508;
    localparam logic [11:0] OFS_ODR = 12'h50c;
    localparam logic [11:0] OFS_PUR = 12'h510;
    localparam logic [11:0] OFS_PDR = 12'h514;
    localparam logic [11:0] OFS_SLR = 12'h518;
    localparam logic [11:0] OFS_DEN = 12'h51c;
    localparam logic [11:0] OFS_IDENT_FIRST = 12'hfd0;
    // Address field that masks the data register
    localparam int DATA_MASK_LSB = 2;
    localparam int DATA_MASK_MSB = 9;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DR2R = 8'hff;
    localparam logic [7:0] RST_PUR = 8'hff;
    localparam logic [7:0] RST_DEN = 8'hff;
    // Port B pin that doubles as the converter trigger
    localparam int ADC_TRIG_PIN = 4;
    // Identification bytes, 0xfd0 upward; values are arbitrary
    localparam logic [7:0] IDENT_VAL [12] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h11, 8'h22, 8'h33, 8'h01, 8'h0a, 8'h5c, 8'h3e, 8'h7b};
    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Pad configuration carried to the pads as one bundle
    typedef struct packed {
        logic [7:0] drive_low_select;
        logic [7:0] drive_mid_select;
        logic [7:0] drive_high_select;
        logic [7:0] slew_control;
        logic [7:0] open_drain_select;
        logic [7:0] pull_up_select;
        logic [7:0] pull_down_select;
        logic [7:0] digital_input_enable;
    } gpb_pad_cfg_t;

    // Interrupt detection settings for the detector
    typedef struct packed {
        logic [7:0] irq_sense_select;
        logic [7:0] irq_both_edges;
        logic [7:0] irq_event_polarity;
    } gpb_irq_cfg_t;
endpackage

/* logic/gpb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pin levels
module gpb_sync #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_reg;

    // Both stages reset low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* logic/gpb_top.sv */
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module gpb_top #(
    parameter logic [7:0] AFSEL_RESET = 8'h00, // Debug pins of this port
    parameter bit ADC_TRIG_EN = 1'b0 // Set on port B only
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave, single word transfers
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pad side: levels in, drive and enable out
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // Peripheral that owns pins with alternate select set
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    output logic [7:0] alt_in,
    output var gpb_pkg::gpb_pad_cfg_t pad_cfg,
    // Towards the interrupt controller and the converter
    output logic port_irq,
    output logic adc_trigger
);
    // Control registers
    logic [7:0] port_data_reg;
    logic [7:0] pin_direction_reg;
    logic [7:0] alt_function_select_reg;
    logic [7:0] irq_mask_reg;
    gpb_pkg::gpb_irq_cfg_t irq_cfg_reg;
    gpb_pkg::gpb_pad_cfg_t pad_reg;
    // Bus data-phase state
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [11:0] addr_reg;
    // Synchronised pin levels
    logic [7:0] pin_sync;
    // Interrupt status
    logic [7:0] irq_raw_status;
    logic [7:0] irq_clear;
    // Combinational next values
    logic [7:0] port_data_next;
    logic [31:0] rdata_next;

    // Byte-lane to 8-bit data, upper bits ignored
    function automatic logic [7:0] wbyte(input logic [31:0] d);
        return d[7:0];
    endfunction

    // Offset match for one register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // Address phase acceptance
    // hready low means a stalled data phase; nothing new is taken
    wire addr_phase = hsel & htrans[gpb_pkg::HTRANS_ACTIVE_BIT] & hready;
    wire take_wr = addr_phase & hwrite;
    wire take_rd = addr_phase & ~hwrite;

    // Data-phase decode from the registered address
    wire sel_data = addr_reg <= gpb_pkg::OFS_DATA_LAST;
    wire [7:0] addr_mask = addr_reg[gpb_pkg::DATA_MASK_MSB:gpb_pkg::DATA_MASK_LSB];
    wire sel_ident = addr_reg >= gpb_pkg::OFS_IDENT_FIRST;
    // Identification bytes count up one word each from the first identity offset
    wire [3:0] ident_idx = 4'(addr_reg[5:2] - 4'h4);
    wire [7:0] wdat = wbyte(hwdata);

    // Write strobes per register
    wire wr_data = wr_pend_reg & sel_data;
    wire wr_dir = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_DIR);
    // Interrupt detection, mask and clear; alternate select
    wire wr_is = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_IS);
    wire wr_ibe = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_IBE);
    wire wr_iev = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_IEV);
    wire wr_im = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_IM);
    wire wr_icr = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_ICR);
    wire wr_afsel = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_AFSEL);
    // Pad configuration
    wire wr_dr2 = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_DR2R);
    wire wr_dr4 = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_DR4R);
    wire wr_dr8 = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_DR8R);
    wire wr_odr = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_ODR);
    wire wr_pur = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_PUR);
    wire wr_pdr = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_PDR);
    wire wr_slr = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_SLR);
    wire wr_den = wr_pend_reg & hit(addr_reg, gpb_pkg::OFS_DEN);

    // Inputs only count where the digital input path is on
    wire [7:0] pin_level = pin_sync & pad_reg.digital_input_enable;
    // Masked status for read-back and the port line
    wire [7:0] irq_masked_status = irq_raw_status & irq_mask_reg;

    // Pin levels are resynchronised before any use
    // Two cycles of input delay buy metastability safety
    gpb_sync #(
        .WIDTH(8)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Write-one clear, only during an interrupt clear write
    // A zero bit leaves its latch alone
    assign irq_clear = wr_icr ? wdat : 8'h00;

    // Edge and level detection per pin
    gpb_irq_detect #(
        .WIDTH(8)
    ) u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(pin_level),
        .cfg(irq_cfg_reg),
        .clear(irq_clear),
        .raw_status(irq_raw_status)
    );

    // Data register: inputs follow the pin, outputs take masked writes
    always_comb begin
        port_data_next = (port_data_reg & pin_direction_reg) | (pin_level & ~pin_direction_reg);
        if (wr_data) begin
            // Only bits both address-selected and outputs change
            port_data_next = (port_data_next & ~(addr_mask & pin_direction_reg))
                | (wdat & addr_mask & pin_direction_reg);
        end
    end

    // Bus slave: writes zero-wait, reads take one wait state
    // so that a read right after a write sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= take_wr;
            rd_pend_reg <= take_rd;
            // Every transfer ends OKAY; nothing is refused
            hresp <= 1'b0;
            if (addr_phase) begin
                addr_reg <= haddr[11:0];
            end
            // Stall the read data phase for one cycle
            hreadyout <= ~take_rd;
        end
    end

    // Read mux over the registered address
    always_comb begin
        rdata_next = 32'h0000_0000;
        // All 256 data aliases share one decode
        if (sel_data) begin
            rdata_next[7:0] = port_data_reg & addr_mask;
        end else if (sel_ident) begin
            rdata_next[7:0] = gpb_pkg::IDENT_VAL[ident_idx];
        end else begin
            unique case (addr_reg)
                gpb_pkg::OFS_DIR: rdata_next[7:0] = pin_direction_reg;
                gpb_pkg::OFS_IS: rdata_next[7:0] = irq_cfg_reg.irq_sense_select;
                gpb_pkg::OFS_IBE: rdata_next[7:0] = irq_cfg_reg.irq_both_edges;
                gpb_pkg::OFS_IEV: rdata_next[7:0] = irq_cfg_reg.irq_event_polarity;
                gpb_pkg::OFS_IM: rdata_next[7:0] = irq_mask_reg;
                gpb_pkg::OFS_RIS: rdata_next[7:0] = irq_raw_status;
                gpb_pkg::OFS_MIS: rdata_next[7:0] = irq_masked_status;
                gpb_pkg::OFS_AFSEL: rdata_next[7:0] = alt_function_select_reg;
                gpb_pkg::OFS_DR2R: rdata_next[7:0] = pad_reg.drive_low_select;
                gpb_pkg::OFS_DR4R: rdata_next[7:0] = pad_reg.drive_mid_select;
                gpb_pkg::OFS_DR8R: rdata_next[7:0] = pad_reg.drive_high_select;
                gpb_pkg::OFS_ODR: rdata_next[7:0] = pad_reg.open_drain_select;
                gpb_pkg::OFS_PUR: rdata_next[7:0] = pad_reg.pull_up_select;
                gpb_pkg::OFS_PDR: rdata_next[7:0] = pad_reg.pull_down_select;
                gpb_pkg::OFS_SLR: rdata_next[7:0] = pad_reg.slew_control;
                gpb_pkg::OFS_DEN: rdata_next[7:0] = pad_reg.digital_input_enable;
                // Clear register and unmapped words read as zero
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data loaded in the stalled cycle
    // Held between reads so the master may sample late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata <= rdata_next;
        end
    end

    // Data, direction and alternate select; any reset returns defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_data_reg <= gpb_pkg::RST_ZERO;
            pin_direction_reg <= gpb_pkg::RST_ZERO;
            alt_function_select_reg <= AFSEL_RESET;
        end else begin
            // A pin turned to output first drives its last sampled level
            port_data_reg <= port_data_next;
            if (wr_dir) begin
                pin_direction_reg <= wdat;
            end
            if (wr_afsel) begin
                alt_function_select_reg <= wdat;
            end
        end
    end

    // Interrupt configuration and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_cfg_reg <= '0;
            irq_mask_reg <= gpb_pkg::RST_ZERO;
        end else begin
            // Changing these with the mask open can raise a false event
            if (wr_is) begin
                irq_cfg_reg.irq_sense_select <= wdat;
            end
            if (wr_ibe) begin
                irq_cfg_reg.irq_both_edges <= wdat;
            end
            if (wr_iev) begin
                irq_cfg_reg.irq_event_polarity <= wdat;
            end
            if (wr_im) begin
                irq_mask_reg <= wdat;
            end
        end
    end

    // Pad configuration; a drive select set in one strength
    // register clears that bit in the other two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_reg <= '0;
            pad_reg.drive_low_select <= gpb_pkg::RST_DR2R;
            pad_reg.pull_up_select <= gpb_pkg::RST_PUR;
            pad_reg.digital_input_enable <= gpb_pkg::RST_DEN;
        end else begin
            if (wr_dr2) begin
                pad_reg.drive_low_select <= wdat;
                pad_reg.drive_mid_select <= pad_reg.drive_mid_select & ~wdat;
                pad_reg.drive_high_select <= pad_reg.drive_high_select & ~wdat;
            end
            if (wr_dr4) begin
                pad_reg.drive_mid_select <= wdat;
                pad_reg.drive_low_select <= pad_reg.drive_low_select & ~wdat;
                pad_reg.drive_high_select <= pad_reg.drive_high_select & ~wdat;
            end
            if (wr_dr8) begin
                pad_reg.drive_high_select <= wdat;
                pad_reg.drive_low_select <= pad_reg.drive_low_select & ~wdat;
                pad_reg.drive_mid_select <= pad_reg.drive_mid_select & ~wdat;
            end
            if (wr_odr) begin
                pad_reg.open_drain_select <= wdat;
            end
            if (wr_pur) begin
                pad_reg.pull_up_select <= wdat;
            end
            if (wr_pdr) begin
                pad_reg.pull_down_select <= wdat;
            end
            // Slew control only matters on the strongest drive
            if (wr_slr) begin
                pad_reg.slew_control <= wdat;
            end
            if (wr_den) begin
                pad_reg.digital_input_enable <= wdat;
            end
        end
    end

    // Pin drive: peripheral or software; open drain only pulls low on software-driven pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            alt_in <= 8'h00;
            pad_cfg <= '0;
        end else begin
            // Registered so every pad signal leaves a flip-flop
            pin_out <= (alt_function_select_reg & alt_out)
                | (~alt_function_select_reg & port_data_reg);
            pin_oe <= (alt_function_select_reg & alt_oe)
                | (~alt_function_select_reg & pin_direction_reg
                & ~(pad_reg.open_drain_select & port_data_reg));
            alt_in <= pin_level;
            pad_cfg <= pad_reg;
        end
    end

    // Port interrupt and converter trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_irq <= 1'b0;
            adc_trigger <= 1'b0;
        end else begin
            port_irq <= |irq_masked_status;
            // Trigger needs the pin 4 mask bit set, like the port line
            adc_trigger <= ADC_TRIG_EN & irq_masked_status[gpb_pkg::ADC_TRIG_PIN];
        end
    end
endmodule
`default_nettype wire

/* verification/gpb_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// External pins and the alternate peripheral seen from the port
module gpb_pins_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    input wire logic [7:0] alt_val,
    output logic [7:0] pin_in,
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe
);
    // Driven pins read back their own level; others show the held outside level
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
    // Peripheral always drives the debug pin, bit 7
    assign alt_out = alt_val;
    assign alt_oe = alt_val | 8'h80;
endmodule
`default_nettype wire

/* verification/gpb_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the port side of the GPIO block; sees top-level ports only
module gpb_top_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] alt_in,
    input wire gpb_pkg::gpb_pad_cfg_t pad_cfg,
    input wire logic port_irq,
    input wire logic adc_trigger
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since reset release; keeps $past away from reset values
    logic [2:0] cyc;
    // Taken transfers, split by direction
    wire rd_take = hsel & htrans[1] & hready & ~hwrite;
    wire wr_take = hsel & htrans[1] & hready & hwrite;
    // Saturating age counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc <= 3'h0;
        end else if (cyc != 3'h7) begin
            cyc <= cyc + 3'h1;
        end
    end
    sequence s_rd_data;
        ##1 !hreadyout ##1 hreadyout;
    endsequence
    property p_data_mask;
        logic [7:0] m;
        (rd_take && haddr[11:10] == 2'b00, m = haddr[9:2]) |-> ##2 ((hrdata[7:0] & ~m) == 8'h00);
    endproperty
    AST_READ_WAIT: assert property (rd_take |-> s_rd_data) else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (wr_take |-> ##1 hreadyout) else $error("write stalled");
    AST_UPPER_ZERO: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
    AST_DATA_MASK: assert property (p_data_mask) else $error("masked data bit read nonzero");
    AST_HRDATA_STANDS: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
    AST_ALT_IN_SYNC: assert property (cyc == 3'h7 && pad_cfg.digital_input_enable == 8'hff
        && $past(pad_cfg.digital_input_enable, 3) == 8'hff |-> alt_in == $past(pin_in, 3))
        else $error("alt_in not synced pin");
    AST_PAD_RESET: assert property (cyc == 3'h1 |-> pad_cfg.drive_low_select == 8'hff
        && pad_cfg.pull_up_select == 8'hff && pad_cfg.drive_high_select == 8'h00)
        else $error("pad reset values wrong");
    AST_IRQ_ADC: assert property (adc_trigger |-> port_irq) else $error("trigger without irq");
endmodule
bind gpb_top gpb_top_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .pin_in(pin_in), .alt_in(alt_in), .pad_cfg(pad_cfg), .port_irq(port_irq), .adc_trigger(adc_trigger));
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_irq, adc_trigger;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext_level, alt_val;
    gpb_pkg::gpb_pad_cfg_t pad_cfg;
    int n_errors, num_checks, cycles;
    // Mode table: sense, both, event, start level, end level, expected raw bit
    logic [5:0] modes [8] = '{6'b001011, 6'b001100, 6'b000101, 6'b010101,
        6'b010011, 6'b101011, 6'b101100, 6'b100101};
    gpb_top #(.AFSEL_RESET(8'h80), .ADC_TRIG_EN(1'b1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .pad_cfg(pad_cfg),
        .port_irq(port_irq), .adc_trigger(adc_trigger));
    gpb_pins_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .alt_val(alt_val),
        .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe));
    // 10 MHz clock, taken as already enabled for the port
    always #50 hclk = ~hclk;
    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One AHB single transfer; waits on hready with no assumed latency
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 8'h00, x);
        check(x, {24'h0, exp});
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Reset values, identification, unmapped space, drive exclusivity
    task automatic t_reset();
        check({24'h0, pin_oe & 8'h7f}, 32'h0);
        check({31'h0, pin_out[7]}, {31'h0, alt_val[7]});
        rd_chk(gpb_pkg::OFS_DIR, 8'h00);
        rd_chk(gpb_pkg::OFS_AFSEL, 8'h80);
        rd_chk(gpb_pkg::OFS_PUR, 8'hff);
        for (int i = 0; i < 12; i++) begin
            wr(gpb_pkg::OFS_IDENT_FIRST + 12'(i * 4), 8'hff);
            rd_chk(gpb_pkg::OFS_IDENT_FIRST + 12'(i * 4), gpb_pkg::IDENT_VAL[i]);
        end
        check({31'h0, hresp}, 32'h0);
        wr(12'h600, 8'h55);
        rd_chk(12'h600, 8'h00);
        wr(gpb_pkg::OFS_DR8R, 8'h01);
        wr(gpb_pkg::OFS_SLR, 8'h01);
        rd_chk(gpb_pkg::OFS_DR2R, 8'hfe);
        rd_chk(gpb_pkg::OFS_SLR, 8'h01);
        check({24'h0, pad_cfg.drive_high_select}, 32'h01);
        $display("t_reset done");
    endtask
    // Address-masked writes and reads, outputs against inputs
    task automatic t_data();
        wr(gpb_pkg::OFS_DIR, 8'h0f);
        wr(12'h098, 8'heb);
        ext_level <= 8'h50;
        repeat (6) @(posedge hclk);
        check({28'h0, pin_out[3:0]}, 32'h2);
        check({28'h0, pin_oe[3:0]}, 32'hf);
        rd_chk(12'h3fc, 8'h52);
        rd_chk(12'h0c4, 8'h10);
        wr(12'h3fc, 8'hff);
        rd_chk(12'h03c, 8'h0f);
        $display("t_data done");
    endtask
    // Alternate function takes pin 0 away from the data register
    task automatic t_alt();
        alt_val <= 8'h80;
        wr(gpb_pkg::OFS_AFSEL, 8'h81);
        repeat (3) @(posedge hclk);
        check({30'h0, pin_out[0], pin_oe[0]}, 32'h0);
        check({31'h0, alt_in[6]}, 32'h1);
        wr(gpb_pkg::OFS_AFSEL, 8'h80);
        repeat (3) @(posedge hclk);
        check({30'h0, pin_out[0], pin_oe[0]}, 32'h3);
        $display("t_alt done");
    endtask
    // Rising edge on pin 4: latch, clear, mask, converter trigger
    task automatic t_irq();
        ext_level <= 8'h40;
        wr(gpb_pkg::OFS_IEV, 8'h10);
        wr(gpb_pkg::OFS_ICR, 8'hff);
        wr(gpb_pkg::OFS_IM, 8'h10);
        repeat (6) @(posedge hclk);
        check({31'h0, port_irq}, 32'h0);
        ext_level <= 8'h50;
        repeat (6) @(posedge hclk);
        check({30'h0, port_irq, adc_trigger}, 32'h3);
        rd_chk(gpb_pkg::OFS_RIS, 8'h10);
        ext_level <= 8'h40;
        repeat (6) @(posedge hclk);
        wr(gpb_pkg::OFS_ICR, 8'h00);
        repeat (3) @(posedge hclk);
        check({31'h0, port_irq}, 32'h1);
        rd_chk(gpb_pkg::OFS_MIS, 8'h10);
        wr(gpb_pkg::OFS_ICR, 8'h10);
        repeat (3) @(posedge hclk);
        check({30'h0, port_irq, adc_trigger}, 32'h0);
        wr(gpb_pkg::OFS_IM, 8'h00);
        ext_level <= 8'h50;
        repeat (6) @(posedge hclk);
        rd_chk(gpb_pkg::OFS_RIS, 8'h10);
        rd_chk(gpb_pkg::OFS_MIS, 8'h00);
        check({31'h0, port_irq}, 32'h0);
        wr(gpb_pkg::OFS_ICR, 8'hff);
        $display("t_irq done");
    endtask
    // Rising, falling, both-edge, high-level and low-level detection on pin 5, mask kept off
    task automatic t_modes();
        for (int i = 0; i < 8; i++) begin
            wr(gpb_pkg::OFS_IS, {2'b0, modes[i][5], 5'b0});
            wr(gpb_pkg::OFS_IBE, {2'b0, modes[i][4], 5'b0});
            wr(gpb_pkg::OFS_IEV, {2'b0, modes[i][3], 5'b0});
            ext_level[5] <= modes[i][2];
            repeat (4) @(posedge hclk);
            wr(gpb_pkg::OFS_ICR, 8'h20);
            ext_level[5] <= modes[i][1];
            repeat (6) @(posedge hclk);
            rd_chk(gpb_pkg::OFS_RIS, {2'b0, modes[i][0], 5'b0});
        end
        $display("t_modes done");
    endtask
    // Reset in mid-run restores direction and debug selection
    task automatic t_reset2();
        wr(gpb_pkg::OFS_DIR, 8'hff);
        wr(gpb_pkg::OFS_AFSEL, 8'h00);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(gpb_pkg::OFS_DIR, 8'h00);
        rd_chk(gpb_pkg::OFS_AFSEL, 8'h80);
        check({24'h0, pin_oe & 8'h7f}, 32'h0);
        $display("t_reset2 done");
    endtask
    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        ext_level = 8'h00;
        alt_val = 8'h00;
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        t_reset();
        t_data();
        t_alt();
        t_irq();
        t_modes();
        t_reset2();
        final_report();
    end
endmodule
`default_nettype wire
